// ### ewl_master.sv
// Bus master model; it drives the bus clock, which is also the link clock
module ewl_master (
	input wire logic clk,
	input wire logic sda_o,
	input wire logic sda_oe,
	output logic scl,
	output logic sda_line
);
	timeunit 1ns;
	timeprecision 1ns;
	logic md = 1'b1;
	initial scl = 1'b1;
	// Open-drain wire with pull-up, so a released line reads high
	assign sda_line = md & (sda_oe ? sda_o : 1'b1);
	// Pacing at the falling edge of the system clock
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	// data moves only while clock low
	task automatic bit_io(input logic b, output logic r);
		wt(5);
		md = b;
		wt(5);
		scl = 1'b1;
		wt(5);
		r = sda_line;
		wt(5);
		scl = 1'b0;
	endtask
	task automatic start();
		md = 1'b1;
		wt(5);
		scl = 1'b1;
		wt(5);
		md = 1'b0;
		wt(5);
		scl = 1'b0;
	endtask
	// stop closes a frame, clock then stands high
	task automatic stop();
		wt(5);
		md = 1'b0;
		wt(5);
		scl = 1'b1;
		wt(5);
		md = 1'b1;
		wt(5);
	endtask
	// Byte out, then the ninth clock with the line released
	task automatic tx(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, ack);
	endtask
	// Byte in; last byte answered high so the device lets go
	task automatic rx(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
	task automatic recover();
		logic r;
		for (int i = 0; i < 9; i++) begin
			bit_io(1'b1, r);
		end
	endtask
endmodule

// ### ewl_pkg.sv
package ewl_pkg;
	// Bus protocol phase
	typedef enum logic [2:0] {P_IDLE, P_DEV, P_WADR, P_WDAT, P_RDAT} ewl_proto_t;
	// Nonvolatile engine phase; boot is the all-zero code
	typedef enum logic [2:0] {NV_BOOT, NV_IDLE, NV_COMMIT, NV_PROG, NV_FINISH} ewl_nv_t;

	// Synchronised pins
	typedef struct packed {
		logic scl;
		logic sda;
		logic wp;
		logic [2:0] strap;
	} ewl_pins_t;

	// State on the link clock
	typedef struct packed {
		logic [7:0] shift;
		logic tgl;
	} ewl_link_t;

	// State on the system clock
	typedef struct packed {
		ewl_proto_t ps;
		ewl_nv_t nv;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic ackp;
		logic [7:0] txd;
		logic sda_oe;
		logic [7:0] ptr;
		logic [7:0] pbase;
		logic [3:0] pcnt;
		logic [2:0] pidx;
		logic [7:0][7:0] pbuf;
		logic wrote;
		logic [23:0] tmr;
		logic lock;
		logic [6:0] w0;
		logic [7:0] w1;
		logic prev_scl;
		logic prev_sda;
		logic tgl_seen;
	} ewl_state_t;
endpackage

// ### ewl_regs.svh
`ifndef EWL_REGS_SVH
`define EWL_REGS_SVH

// Memory map
`define EWL_ADDR_WIPER_ONE 8'hf8
`define EWL_ADDR_WIPER_ZERO 8'hf9
`define EWL_ADDR_PROTECT 8'hfa
`define EWL_ADDR_KEY_FIRST 8'hfb
`define EWL_ADDR_KEY_SECOND 8'hfc
`define EWL_HIGH_BLOCK_LO 8'h80
`define EWL_HIGH_BLOCK_HI 8'hf7
`define EWL_LOW_BLOCK_HI 8'h7f
// Protect byte fields
`define EWL_BIT_TOP_PAGE 2
`define EWL_BIT_HIGH_BLOCK 1
`define EWL_BIT_LOW_BLOCK 0
// Key values
`define EWL_LOCK_KEY_FIRST 8'h56
`define EWL_LOCK_KEY_SECOND 8'h25
`define EWL_UNLOCK_KEY_FIRST 8'h67
`define EWL_UNLOCK_KEY_SECOND 8'h36
// Wiper zero top position and page size
`define EWL_WIPER_ZERO_MAX 7'h63
`define EWL_PAGE_BYTES 4'h8
// Timing: clock period and internal write time, in ns
`define EWL_CLK_NS 50
`define EWL_T_WR_NS 5000000
`endif

// ### ewl_slave.sv
`include "ewl_regs.svh"
module ewl_slave #(
	parameter int WR_NS = `EWL_T_WR_NS,
	parameter logic [3:0] DEV_TYPE = 4'h5 // Type nibble, value arbitrary
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic wp_i,
	input wire logic addr_strap_0,
	input wire logic addr_strap_1,
	input wire logic addr_strap_2,
	output logic [6:0] wiper_zero_out,
	output logic [7:0] wiper_one_out,
	output logic standby
);
	// Internal write time rounded up to whole clocks, never below one
	localparam int WR_CYC_I = (WR_NS + `EWL_CLK_NS - 1) / `EWL_CLK_NS;
	localparam logic [23:0] WR_CYC = 24'((WR_CYC_I < 1) ? 1 : WR_CYC_I);

	ewl_pkg::ewl_pins_t pin_raw;
	ewl_pkg::ewl_pins_t pin_s;
	ewl_pkg::ewl_link_t lk_r;
	ewl_pkg::ewl_link_t lk_nxt;
	ewl_pkg::ewl_state_t r;
	ewl_pkg::ewl_state_t n;
	logic tgl_s;
	logic ev_rise;
	logic ev_fall;
	logic ev_start;
	logic ev_stop;
	logic bit_in;
	logic [7:0] byte_v;
	logic [7:0] wa;
	logic [6:0] v0;
	logic dev_match;
	logic mem_we;
	logic [7:0] mem_wa;
	logic [7:0] mem_wd;
	logic [2:0] cfg;

	logic [7:0] mem [256];

	// Pins cross into the system clock through two flops
	assign pin_raw = '{scl: scl, sda: sda_i, wp: wp_i,
		strap: {addr_strap_2, addr_strap_1, addr_strap_0}};

	ewl_sync #(.W($bits(ewl_pkg::ewl_pins_t))) u_pin_sync (
		.clk(clk),
		.rst(rst),
		.d(pin_raw),
		.q(pin_s)
	);

	// Link domain: SDA is shifted in on each SCL rise and a toggle marks it.
	// The shift word is held a whole SCL period, far longer than the toggle
	// needs to cross, so the system side may read it once the toggle lands.
	always_comb begin
		lk_nxt = lk_r;
		lk_nxt.shift = {lk_r.shift[6:0], sda_i};
		lk_nxt.tgl = ~lk_r.tgl;
	end

	always_ff @(posedge scl or posedge rst) begin
		if (rst) begin
			lk_r <= '0;
		end else begin
			lk_r <= lk_nxt;
		end
	end

	ewl_sync #(.W(1)) u_tgl_sync (
		.clk(clk),
		.rst(rst),
		.d(lk_r.tgl),
		.q(tgl_s)
	);

	// Bus events seen on the system clock
	assign ev_rise = tgl_s != r.tgl_seen;
	assign bit_in = lk_r.shift[0];
	assign ev_fall = r.prev_scl & ~pin_s.scl;
	assign ev_start = pin_s.scl & r.prev_scl & r.prev_sda & ~pin_s.sda;
	assign ev_stop = pin_s.scl & r.prev_scl & ~r.prev_sda & pin_s.sda;
	assign cfg = mem[`EWL_ADDR_PROTECT][2:0];

	// Software protection; the key bytes stay writable so a lock can be undone
	function automatic logic prot_f(input logic [7:0] a, input logic [2:0] c,
			input logic lk, input logic wp);
		logic top;
		logic key;
		logic hi;
		logic lo;
		// upper page lock guards the protect byte
		top = a >= `EWL_ADDR_WIPER_ONE;
		key = (a == `EWL_ADDR_KEY_FIRST) || (a == `EWL_ADDR_KEY_SECOND);
		hi = (a >= `EWL_HIGH_BLOCK_LO) && (a <= `EWL_HIGH_BLOCK_HI);
		lo = a <= `EWL_LOW_BLOCK_HI;
		prot_f = wp | (lk & ((top & ~key & c[`EWL_BIT_TOP_PAGE]) |
			(hi & c[`EWL_BIT_HIGH_BLOCK]) | (lo & c[`EWL_BIT_LOW_BLOCK])));
	endfunction

	// Next state of the protocol and the nonvolatile engine
	always_comb begin
		n = r;
		mem_we = 1'b0;
		mem_wa = r.pbase;
		mem_wd = 8'h00;
		wa = r.pbase + {5'h00, r.pidx};
		v0 = mem[`EWL_ADDR_WIPER_ZERO][6:0];
		byte_v = {r.shreg[6:0], bit_in};
		dev_match = (byte_v[7:4] == DEV_TYPE) && (byte_v[3:1] == pin_s.strap) &&
			(r.nv == ewl_pkg::NV_IDLE);
		n.prev_scl = pin_s.scl;
		n.prev_sda = pin_s.sda;
		n.tgl_seen = tgl_s;

		if (ev_start) begin
			n.ps = ewl_pkg::P_DEV;
			n.cnt = 4'h0;
			n.sda_oe = 1'b0;
			if (r.nv == ewl_pkg::NV_IDLE) begin
				n.pcnt = 4'h0;
			end
		end else if (ev_stop) begin
			if (r.ps == ewl_pkg::P_WDAT && r.pcnt != 4'h0 && r.nv == ewl_pkg::NV_IDLE) begin
				n.nv = ewl_pkg::NV_COMMIT;
				n.pidx = 3'h0;
				n.wrote = 1'b0;
			end
			n.ps = ewl_pkg::P_IDLE;
			n.sda_oe = 1'b0;
			n.cnt = 4'h0;
		end else if (r.ps != ewl_pkg::P_IDLE) begin
			if (ev_rise) begin
				n.cnt = r.cnt + 4'h1;
				if (r.cnt < 4'h8) begin
					n.shreg = byte_v;
				end
				if (r.cnt == 4'h7) begin
					n.ackp = 1'b1;
					unique case (r.ps)
						ewl_pkg::P_DEV: begin
							if (dev_match) begin
								n.ps = byte_v[0] ? ewl_pkg::P_RDAT : ewl_pkg::P_WADR;
							end else begin
								n.ps = ewl_pkg::P_IDLE;
								n.ackp = 1'b0;
							end
						end
						ewl_pkg::P_WADR: begin
							n.ptr = byte_v;
							n.pbase = byte_v;
							n.pcnt = 4'h0;
							n.ps = ewl_pkg::P_WDAT;
						end
						ewl_pkg::P_WDAT: begin
							// bytes past eight are acknowledged and dropped
							if (r.pcnt < `EWL_PAGE_BYTES) begin
								n.pbuf[r.pcnt[2:0]] = byte_v;
								n.pcnt = r.pcnt + 4'h1;
							end
							n.ptr = r.ptr + 8'h01;
						end
						ewl_pkg::P_RDAT: begin
							n.ackp = 1'b0;
						end
						ewl_pkg::P_IDLE: begin
							n.ackp = 1'b0;
						end
					endcase
				end
				// Master leaves SDA high on the ninth clock: read ends
				if (r.cnt == 4'h8 && r.ps == ewl_pkg::P_RDAT && bit_in) begin
					n.ps = ewl_pkg::P_IDLE;
				end
			end else if (ev_fall) begin
				if (r.cnt == 4'h8) begin
					n.sda_oe = r.ackp;
				end else if (r.cnt == 4'h9) begin
					n.cnt = 4'h0;
					n.sda_oe = 1'b0;
					if (r.ps == ewl_pkg::P_RDAT) begin
						n.sda_oe = ~mem[r.ptr][7];
						n.txd = {mem[r.ptr][6:0], 1'b0};
						n.ptr = r.ptr + 8'h01;
					end
				end else if (r.ps == ewl_pkg::P_RDAT && r.cnt != 4'h0) begin
					// Next data bit goes out on the falling edge
					n.sda_oe = ~r.txd[7];
					n.txd = {r.txd[6:0], 1'b0};
				end
			end
		end

		// Nonvolatile engine: one byte per clock, then the program time if any byte was written
		unique case (r.nv)
			ewl_pkg::NV_BOOT: begin
				n.nv = ewl_pkg::NV_FINISH;
			end
			ewl_pkg::NV_IDLE: begin
				n.tmr = 24'h000000;
			end
			ewl_pkg::NV_COMMIT: begin
				if (!prot_f(wa, cfg, r.lock, pin_s.wp)) begin
					mem_we = 1'b1;
					mem_wa = wa;
					mem_wd = r.pbuf[r.pidx];
					n.wrote = 1'b1;
				end
				n.pidx = r.pidx + 3'h1;
				if ({1'b0, r.pidx} + 4'h1 == r.pcnt) begin
					n.nv = n.wrote ? ewl_pkg::NV_PROG : ewl_pkg::NV_FINISH;
					n.tmr = WR_CYC - 24'h000001;
				end
			end
			ewl_pkg::NV_PROG: begin
				if (r.tmr == 24'h000000) begin
					n.nv = ewl_pkg::NV_FINISH;
				end else begin
					n.tmr = r.tmr - 24'h000001;
				end
			end
			ewl_pkg::NV_FINISH: begin
				n.w0 = (v0 > `EWL_WIPER_ZERO_MAX) ? `EWL_WIPER_ZERO_MAX : v0;
				// wiper one takes the whole byte
				n.w1 = mem[`EWL_ADDR_WIPER_ONE];
				if (mem[`EWL_ADDR_KEY_FIRST] == `EWL_LOCK_KEY_FIRST &&
						mem[`EWL_ADDR_KEY_SECOND] == `EWL_LOCK_KEY_SECOND) begin
					n.lock = 1'b1;
				end else if (mem[`EWL_ADDR_KEY_FIRST] == `EWL_UNLOCK_KEY_FIRST &&
						mem[`EWL_ADDR_KEY_SECOND] == `EWL_UNLOCK_KEY_SECOND) begin
					n.lock = 1'b0;
				end
				n.nv = ewl_pkg::NV_IDLE;
			end
			default: begin
				n.nv = ewl_pkg::NV_IDLE;
			end
		endcase
	end

	// State register; boot code is all zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// Array holds no reset: its contents are nonvolatile
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	// Outputs; SDA is open drain so only the enable moves
	assign sda_o = 1'b0;
	assign sda_oe = r.sda_oe;
	// wipers from flops loaded after programming
	assign wiper_zero_out = r.w0;
	assign wiper_one_out = r.w1;
	// standby when bus and engine are idle
	assign standby = (r.ps == ewl_pkg::P_IDLE) && (r.nv == ewl_pkg::NV_IDLE);

	// Checks on the system clock
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_ack_fall;
		ev_fall && r.cnt == 4'h8 && r.ackp;
	endsequence

	sequence s_dev_byte_done;
		ev_rise && !ev_start && !ev_stop && r.cnt == 4'h7 && r.ps == ewl_pkg::P_DEV;
	endsequence

	sequence s_finish;
		r.nv == ewl_pkg::NV_FINISH;
	endsequence

	AST_START_RESYNC: assert property (ev_start |=>
		r.ps == ewl_pkg::P_DEV && r.cnt == 4'h0 && !sda_oe)
		else $error("start did not resync the receiver");

	AST_ACK_NINTH: assert property (s_ack_fall ##0 (!ev_start && !ev_stop) |=>
		sda_oe [*4])
		else $error("acknowledge not held low");

	AST_STRAP_MISMATCH: assert property (s_dev_byte_done ##0
		(byte_v[3:1] != pin_s.strap) |=> r.ps == ewl_pkg::P_IDLE && !r.ackp)
		else $error("address with wrong straps accepted");

	AST_TYPE_MATCH: assert property (s_dev_byte_done ##0 dev_match |=>
		r.ackp && r.ps != ewl_pkg::P_IDLE)
		else $error("matching address not acknowledged");

	AST_STOP_STANDBY: assert property ((ev_stop && r.nv == ewl_pkg::NV_IDLE &&
		r.ps != ewl_pkg::P_WDAT) |=> standby)
		else $error("stop did not enter standby");

	AST_PAGE_DROP: assert property ((ev_start && r.nv == ewl_pkg::NV_IDLE) |=>
		r.pcnt == 4'h0 && r.nv == ewl_pkg::NV_IDLE)
		else $error("page kept without stop");

	AST_WP_BLOCKS: assert property (pin_s.wp |-> !mem_we)
		else $error("write while protect pin high");

	AST_PROT_SKIP: assert property ((r.nv == ewl_pkg::NV_COMMIT &&
		prot_f(wa, cfg, r.lock, pin_s.wp)) |-> !mem_we ##1 !$changed(r.wrote) || r.wrote)
		else $error("protected byte written");

	AST_WIPER0_CLAMP: assert property ((s_finish ##0
		(mem[`EWL_ADDR_WIPER_ZERO][6:0] > `EWL_WIPER_ZERO_MAX)) |=>
		wiper_zero_out == `EWL_WIPER_ZERO_MAX)
		else $error("wiper zero above top position");

	AST_WIPER1_FOLLOW: assert property ((s_finish ##0 r.wrote) |=>
		wiper_one_out == $past(mem[`EWL_ADDR_WIPER_ONE]))
		else $error("wiper one not updated");

	AST_LOCK_KEY: assert property ((s_finish ##0
		(mem[`EWL_ADDR_KEY_FIRST] == `EWL_LOCK_KEY_FIRST) &&
		(mem[`EWL_ADDR_KEY_SECOND] == `EWL_LOCK_KEY_SECOND)) |=> r.lock)
		else $error("lock key ignored");

	AST_UNLOCK_KEY: assert property ((s_finish ##0
		(mem[`EWL_ADDR_KEY_FIRST] == `EWL_UNLOCK_KEY_FIRST) &&
		(mem[`EWL_ADDR_KEY_SECOND] == `EWL_UNLOCK_KEY_SECOND)) |=> !r.lock)
		else $error("unlock key ignored");

	AST_PTR_WRAP: assert property ((ev_fall && !ev_start && !ev_stop && r.cnt == 4'h9 &&
		r.ps == ewl_pkg::P_RDAT && r.ptr == 8'hff) |=> r.ptr == 8'h00)
		else $error("address did not wrap");
endmodule

// ### ewl_slave_test.sv
module ewl_slave_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] DTYPE = 4'h5;
	logic clk = 1'b0;
	logic rst = 1'b0;
	logic wp = 1'b0;
	logic [2:0] strap = 3'h5;
	logic scl, sda_line, sda_o, sda_oe, standby;
	logic [6:0] w0;
	logic [7:0] w1;
	int mismatches = 0;
	int n_checks = 0;
	// 20 MHz system clock
	always #25 clk = ~clk;
	// Short write time keeps the run brief
	ewl_slave #(.WR_NS(2000), .DEV_TYPE(DTYPE)) u_ewl_slave (.clk(clk), .rst(rst), .scl(scl),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp), .addr_strap_0(strap[0]),
		.addr_strap_1(strap[1]), .addr_strap_2(strap[2]), .wiper_zero_out(w0), .wiper_one_out(w1),
		.standby(standby));
	ewl_master u_ewl_master (.clk(clk), .sda_o(sda_o), .sda_oe(sda_oe), .scl(scl), .sda_line(sda_line));
	// Compare and count
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Single place where the run ends
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Acknowledge polling bounds the wait for the write cycle
	task automatic poll();
		logic k;
		k = 1'b1;
		for (int i = 0; i < 40 && k; i++) begin
			u_ewl_master.start();
			u_ewl_master.tx({DTYPE, strap, 1'b0}, k);
			u_ewl_master.stop();
		end
		u_ewl_master.wt(10);
		chk("poll ack", 8'h00, {7'h00, k});
		chk("standby", 8'h01, {7'h00, standby});
	endtask
	// Page write, every byte acknowledged even when protected
	task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
		logic k;
		u_ewl_master.start();
		u_ewl_master.tx({DTYPE, strap, 1'b0}, k);
		chk("addr ack", 8'h00, {7'h00, k});
		u_ewl_master.tx(a, k);
		chk("word ack", 8'h00, {7'h00, k});
		foreach (d[i]) begin
			u_ewl_master.tx(d[i], k);
			chk("data ack", 8'h00, {7'h00, k});
		end
		u_ewl_master.stop();
		poll();
	endtask
	// Random read followed by a sequential run
	task automatic rd(input logic [7:0] a, input logic [7:0] e[$]);
		logic k;
		logic [7:0] d;
		u_ewl_master.start();
		u_ewl_master.tx({DTYPE, strap, 1'b0}, k);
		u_ewl_master.tx(a, k);
		u_ewl_master.start();
		u_ewl_master.tx({DTYPE, strap, 1'b1}, k);
		chk("read ack", 8'h00, {7'h00, k});
		foreach (e[i]) begin
			u_ewl_master.rx(i == e.size() - 1, d);
			chk("read data", e[i], d);
		end
		u_ewl_master.stop();
	endtask
	// Only the strapped address and the right type are answered
	task automatic s_straps();
		logic k;
		for (int s = 0; s < 8; s++) begin
			u_ewl_master.start();
			u_ewl_master.tx({DTYPE, 3'(s), 1'b0}, k);
			u_ewl_master.stop();
			chk("strap ack", {7'h00, 3'(s) != strap}, {7'h00, k});
		end
		u_ewl_master.start();
		u_ewl_master.tx({~DTYPE, strap, 1'b0}, k);
		u_ewl_master.stop();
		chk("type ack", 8'h01, {7'h00, k});
	endtask
	// Wiper bytes first, so after the boot load no wiper is loaded from an unwritten byte, then unlock keys and the clamp
	task automatic s_wipers();
		wr(8'hf8, '{8'ha5, 8'h85});
		chk("wiper one", 8'ha5, w1);
		chk("wiper zero", 8'h05, {1'b0, w0});
		wr(8'hfb, '{8'h67, 8'h36});
		wr(8'hf9, '{8'h7f});
		chk("wiper zero top", 8'h63, {1'b0, w0});
	endtask
	// Page crossing the top of the array wraps to zero
	task automatic s_wrap();
		wr(8'hfe, '{8'h11, 8'h22, 8'h33});
		wr(8'h80, '{8'h44});
		rd(8'hfe, '{8'h11, 8'h22, 8'h33});
	endtask
	// Nine bytes into one page: the ninth is dropped, then a current address read
	task automatic s_page();
		logic k;
		logic [7:0] d;
		wr(8'h18, '{8'h5a});
		wr(8'h10, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h99});
		rd(8'h10, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08});
		u_ewl_master.start();
		u_ewl_master.tx({DTYPE, strap, 1'b1}, k);
		chk("current ack", 8'h00, {7'h00, k});
		u_ewl_master.rx(1'b1, d);
		u_ewl_master.stop();
		chk("current read", 8'h5a, d);
	endtask
	// Lock both blocks, then the upper page, then unlock again
	task automatic s_lock();
		wr(8'hfa, '{8'h03});
		wr(8'hfb, '{8'h56, 8'h25});
		wr(8'h00, '{8'haa});
		wr(8'h80, '{8'hbb});
		rd(8'h00, '{8'h33});
		rd(8'h80, '{8'h44});
		wr(8'hfa, '{8'h07});
		wr(8'hf8, '{8'h00});
		wr(8'hfa, '{8'h00});
		chk("wiper one", 8'ha5, w1);
		rd(8'hf8, '{8'ha5, 8'h7f, 8'h07});
		wr(8'hfb, '{8'h67, 8'h36});
		wr(8'h00, '{8'haa});
		rd(8'h00, '{8'haa});
	endtask
	// Pin protection blocks wiper changes
	task automatic s_wp();
		wp = 1'b1;
		wr(8'hf8, '{8'h11});
		wp = 1'b0;
		chk("wiper one", 8'ha5, w1);
		rd(8'hf8, '{8'ha5});
	endtask
	// Abort mid address, recover, then a normal read
	task automatic s_recover();
		logic k;
		u_ewl_master.start();
		for (int i = 3; i > 0; i--) begin
			u_ewl_master.bit_io(DTYPE[i], k);
		end
		u_ewl_master.recover();
		rd(8'h00, '{8'haa});
	endtask
	// Main sequence; reset gets a true rising edge so the flops on the bus clock clear too
	initial begin
		#1 rst = 1'b1;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (6) @(negedge clk);
		chk("boot standby", 8'h01, {7'h00, standby});
		s_straps();
		s_wipers();
		s_wrap();
		s_page();
		s_lock();
		s_wp();
		s_recover();
		close_out();
	end
	// Watchdog well beyond the expected run
	initial begin
		repeat (80000) @(negedge clk);
		mismatches++;
		close_out();
	end
endmodule

// ### ewl_sync.sv
// Two-stage synchroniser; the first stage feeds only the second
module ewl_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// Both stages reset to zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;
endmodule
